// ---- design/reconfig_access_port.sv ----
/*
 Shared reconfiguration access port for a multi-channel transceiver tile:
 one slave port, channel-select decode, embedded debug agent arbitration,
 capability and soft control/status registers, and a profile streamer.
 Assumes the master and the debug agent run on sys_clk; phy_status is
 asynchronous and is synchronised here.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
// Functional notes
// - one shared slave port for all channels
// - address bits above 18 select channel
// - low nineteen bits give register offset
// - port present only when reconfiguration enabled
// - debug agent reaches channel space internally
// - multi-channel debug needs shared interface
// - separated wait-request; arbitration in status bit
// - separation off by default, needs soft registers
// - capability registers describe configuration
// - user identifier readable, default zero
// - soft registers read status, drive control
// - streamer applies stored profile automatically
// - one to eight stored profiles
`timescale 1ns/10ps
`default_nettype none
module reconfig_access_port
	import reconfig_port_pkg::*;
#(
	parameter bit          RECONFIG_EN  = 1'b1,
	parameter bit          DBG_EN       = 1'b1,
	parameter bit          WAIT_SEP     = 1'b0,
	parameter bit          CAP_EN       = 1'b1,
	parameter bit          CSR_EN       = 1'b1,
	parameter bit          STRM_EN      = 1'b1,
	parameter logic [31:0] USER_ID      = 32'h0,
	parameter int          NUM_PROFILES = 8
) (
	input  wire logic              sys_clk,              // System clock
	input  wire logic              reset,                // Synchronous reset
	input  wire bus_req_t          user_req,             // Master request
	output var  logic [DATA_W-1:0] user_rdata,           // Master read data
	output var  logic              reconfig_waitrequest, // Master stall
	input  wire logic              dbg_req,              // Debug agent wants port
	input  wire bus_req_t          dbg_bus,              // Debug agent request
	output var  logic [DATA_W-1:0] dbg_rdata,            // Debug read data
	input  wire logic [CTRL_W-1:0] phy_status,           // PHY status pins
	output var  logic [CTRL_W-1:0] phy_ctrl,             // PHY control pins
	output var  logic              strm_busy             // Streamer running
);
	localparam bit SHARED_IF = 1'b1;
	localparam bit DBG_OK   = DBG_EN && (SHARED_IF || NUM_CH == 1);
	localparam bit WAIT_EFF = WAIT_SEP && CSR_EN;

	owner_t            owner_q;
	owner_t            owner_d;
	strm_state_t       strm_state_q;
	logic [PROF_IW-1:0] strm_idx_q;
	logic [PROF_PW-1:0] strm_prof_q;
	logic [CH_W-1:0]   strm_ch_q;
	logic              strm_err_q;
	logic [CTRL_W-1:0] stat_meta_q;
	logic [CTRL_W-1:0] stat_sync_q;
	logic [DATA_W-1:0] attr_q [NUM_CH*ATTR_WORDS];
	logic [DATA_W-1:0] prof_q [PROF_MAX*PROF_WORDS];
	bus_req_t          act;
	logic              act_attr;
	logic              act_wr;
	logic              strm_go;
	logic              strm_bad;
	logic              user_soft;
	logic              dbg_soft;

	function automatic logic is_attr(input logic [ADDR_W-1:0] a);
		is_attr = (a[OFF_W-1:ATTR_AW] == '0);
	endfunction

	function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
		logic [OFF_W-1:0] off;
		off = a[OFF_W-1:0];
		rd_word = 32'h0;
		if (is_attr(a))
			rd_word = attr_q[{a[ADDR_W-1:OFF_W], off[ATTR_AW-1:0]}];
		else if (CAP_EN && off == CAP_NUM_CH_OFF)
			rd_word = 32'(NUM_CH);
		else if (CAP_EN && off == CAP_USER_ID_OFF)
			rd_word = USER_ID;
		else if (CAP_EN && off == CAP_FEATURE_OFF)
			rd_word = {20'h0, 4'(NUM_PROFILES), 4'h0, STRM_EN, WAIT_EFF, CSR_EN, DBG_OK};
		else if (CSR_EN && off == CSR_CTRL_OFF)
			rd_word = {24'h0, phy_ctrl};
		else if (CSR_EN && off == CSR_STATUS_OFF)
			rd_word = {owner_q != OWN_USER, 23'h0, stat_sync_q};
		else if (STRM_EN && off == STRM_STATUS_OFF)
			rd_word = {26'h0, strm_err_q, strm_state_q == ST_RUN, 1'b0, strm_prof_q};
		else if (STRM_EN && off[OFF_W-1:5] == PROF_BASE_OFF[OFF_W-1:5])
			rd_word = prof_q[off[4:0]];
	endfunction

	always_comb begin
		act = '0;
		if (owner_q == OWN_USER)
			act = user_req;
		else if (owner_q == OWN_DBG)
			act = dbg_bus;
		act_wr   = RECONFIG_EN && act.wr;
		act_attr = is_attr(act.addr);
	end

	always_comb begin
		strm_go  = 1'b0;
		strm_bad = 1'b0;
		if (STRM_EN && act_wr && act.addr[OFF_W-1:0] == STRM_CTRL_OFF && act.wdata[CTRL_START_BIT]) begin
			if ({1'b0, act.wdata[CTRL_PROF_LSB +: PROF_PW]} < 4'(NUM_PROFILES))
				strm_go = 1'b1;
			else
				strm_bad = 1'b1;
		end
	end

	always_comb begin
		owner_d = OWN_USER;
		if (RECONFIG_EN && (strm_state_q == ST_RUN || strm_go))
			owner_d = OWN_STRM;
		else if (RECONFIG_EN && DBG_OK && dbg_req)
			owner_d = OWN_DBG;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			owner_q              <= OWN_USER;
			reconfig_waitrequest <= 1'b0;
		end else begin
			owner_q              <= owner_d;
			reconfig_waitrequest <= !WAIT_EFF && owner_d != OWN_USER;
		end
	end

	// Status pins are asynchronous
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stat_meta_q <= '0;
			stat_sync_q <= '0;
		end else begin
			stat_meta_q <= phy_status;
			stat_sync_q <= stat_meta_q;
		end
	end

	// Soft registers stay readable while another master owns the channels
	assign user_soft = !is_attr(user_req.addr);
	assign dbg_soft  = !is_attr(dbg_bus.addr);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			user_rdata <= '0;
			dbg_rdata  <= '0;
		end else begin
			user_rdata <= '0;
			dbg_rdata  <= '0;
			if (RECONFIG_EN && user_req.rd && (owner_q == OWN_USER || user_soft))
				user_rdata <= rd_word(user_req.addr);
			if (RECONFIG_EN && DBG_OK && dbg_bus.rd && (owner_q == OWN_DBG || dbg_soft))
				dbg_rdata <= rd_word(dbg_bus.addr);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			phy_ctrl <= PHY_CTRL_RST;
		else if (CSR_EN && act_wr && act.addr[OFF_W-1:0] == CSR_CTRL_OFF)
			phy_ctrl <= act.wdata[CTRL_W-1:0];
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strm_state_q <= ST_IDLE;
			strm_idx_q   <= '0;
			strm_prof_q  <= '0;
			strm_ch_q    <= '0;
			strm_err_q   <= 1'b0;
			strm_busy    <= 1'b0;
		end else begin
			case (strm_state_q)
				ST_IDLE: begin
					if (strm_go) begin
						strm_state_q <= ST_RUN;
						strm_idx_q   <= '0;
						strm_prof_q  <= act.wdata[CTRL_PROF_LSB +: PROF_PW];
						strm_ch_q    <= act.wdata[CTRL_CH_LSB +: CH_W];
						strm_err_q   <= 1'b0;
						strm_busy    <= 1'b1;
					end else if (strm_bad) begin
						strm_err_q <= 1'b1;
					end
				end
				ST_RUN: begin
					strm_idx_q <= strm_idx_q + 2'h1;
					if (strm_idx_q == PROF_IW'(PROF_WORDS - 1)) begin
						strm_state_q <= ST_IDLE;
						strm_busy    <= 1'b0;
					end
				end
				default: strm_state_q <= ST_IDLE;
			endcase
		end
	end

	// Channel space has one write port; streamer owns it while running
	always_ff @(posedge sys_clk) begin
		if (strm_state_q == ST_RUN)
			attr_q[{strm_ch_q, {(ATTR_AW-PROF_IW){1'b0}}, strm_idx_q}] <= prof_q[{strm_prof_q, strm_idx_q}];
		else if (act_wr && act_attr)
			attr_q[{act.addr[ADDR_W-1:OFF_W], act.addr[ATTR_AW-1:0]}] <= act.wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (STRM_EN && act_wr && act.addr[OFF_W-1:5] == PROF_BASE_OFF[OFF_W-1:5])
			prof_q[act.addr[4:0]] <= act.wdata;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_wait_on_grant: assert property ((!WAIT_EFF && owner_q != OWN_USER) |-> reconfig_waitrequest)
		else $error("waitrequest low while master not granted");
	a_wait_separated: assert property (WAIT_EFF |-> !reconfig_waitrequest)
		else $error("waitrequest raised while separated");
	a_arb_status_bit: assert property ((CSR_EN && user_req.rd && user_req.addr[OFF_W-1:0] == CSR_STATUS_OFF)
		|=> user_rdata[STATUS_ARB_BIT] == ($past(owner_q) != OWN_USER))
		else $error("arbitration status bit wrong");
	a_user_id_read: assert property ((RECONFIG_EN && CAP_EN && user_req.rd && user_req.addr[OFF_W-1:0] == CAP_USER_ID_OFF)
		|=> user_rdata == USER_ID)
		else $error("user identifier read wrong");
	// Master leaves one idle cycle after a write; nothing else may write in it
	a_chan_roundtrip: assert property ((RECONFIG_EN && owner_q == OWN_USER && user_req.wr && is_attr(user_req.addr)
		&& owner_d == OWN_USER) ##1 (owner_q == OWN_USER && !act_wr) ##1 (owner_q == OWN_USER && user_req.rd
		&& user_req.addr == $past(user_req.addr, 2)) |=> user_rdata == $past(user_req.wdata, 3))
		else $error("channel word not read back");
	a_ctrl_drive: assert property ((CSR_EN && act_wr && act.addr[OFF_W-1:0] == CSR_CTRL_OFF)
		|=> phy_ctrl == $past(act.wdata[CTRL_W-1:0]))
		else $error("control pins not updated");
	a_dbg_blocked: assert property (!DBG_OK |-> owner_q != OWN_DBG)
		else $error("debug agent granted when not permitted");
	a_no_reconfig: assert property (!RECONFIG_EN |=> user_rdata == '0 && dbg_rdata == '0)
		else $error("access answered without reconfiguration");
	a_strm_length: assert property ($rose(strm_state_q == ST_RUN) |-> (strm_state_q == ST_RUN)[*4] ##1 strm_state_q == ST_IDLE)
		else $error("streamer length wrong");
	a_strm_profile: assert property ((strm_state_q == ST_IDLE && strm_bad) |=> strm_state_q == ST_IDLE && strm_err_q)
		else $error("out of range profile started");
	a_dbg_cap_read: assert property ((RECONFIG_EN && DBG_OK && CAP_EN && dbg_bus.rd
		&& dbg_bus.addr[OFF_W-1:0] == CAP_NUM_CH_OFF) |=> dbg_rdata == 32'(NUM_CH))
		else $error("debug capability read wrong");
	a_dbg_id_read: assert property ((RECONFIG_EN && DBG_OK && CAP_EN && dbg_bus.rd
		&& dbg_bus.addr[OFF_W-1:0] == CAP_USER_ID_OFF) |=> dbg_rdata == USER_ID)
		else $error("debug identifier read wrong");

	// Feature word fields must not shift when options change
	a_feature_read: assert property ((RECONFIG_EN && CAP_EN && user_req.rd
		&& user_req.addr[OFF_W-1:0] == CAP_FEATURE_OFF) |=> user_rdata[31:12] == '0
		&& user_rdata[11:8] == 4'(NUM_PROFILES) && user_rdata[7:4] == '0
		&& user_rdata[3:0] == {STRM_EN, WAIT_EFF, CSR_EN, DBG_OK})
		else $error("feature word wrong");
	a_ctrl_readback: assert property ((RECONFIG_EN && CSR_EN && user_req.rd
		&& user_req.addr[OFF_W-1:0] == CSR_CTRL_OFF) |=> user_rdata == {24'h0, $past(phy_ctrl)})
		else $error("control readback wrong");
	a_ctrl_hold: assert property (!(CSR_EN && act_wr && act.addr[OFF_W-1:0] == CSR_CTRL_OFF) |=> $stable(phy_ctrl))
		else $error("control pins moved without a write");

	// Read data stands one cycle only, else zero
	a_rdata_idle: assert property (!(RECONFIG_EN && user_req.rd) |=> user_rdata == '0)
		else $error("read data without a read");
	a_dbg_rdata_idle: assert property (!(RECONFIG_EN && DBG_OK && dbg_bus.rd) |=> dbg_rdata == '0)
		else $error("debug read data without a read");
	a_ungranted_read: assert property ((user_req.rd && is_attr(user_req.addr)
		&& owner_q != OWN_USER) |=> user_rdata == '0)
		else $error("ungranted channel read answered");
	a_wait_released: assert property ((!WAIT_EFF && owner_q == OWN_USER) |-> !reconfig_waitrequest)
		else $error("waitrequest high while master granted");
	a_dbg_granted: assert property ((owner_q == OWN_DBG) |-> $past(dbg_req))
		else $error("debug agent granted without request");

	// Streamer keeps the port for the whole profile
	a_strm_busy_run: assert property (strm_busy == (strm_state_q == ST_RUN))
		else $error("busy flag disagrees with streamer");
	a_strm_owns_port: assert property ((strm_state_q == ST_RUN) |-> owner_q == OWN_STRM)
		else $error("streamer running without the port");
	a_strm_start: assert property ((strm_state_q == ST_IDLE && strm_go)
		|=> strm_state_q == ST_RUN && strm_busy && !strm_err_q)
		else $error("valid profile did not start");
	a_strm_prof_range: assert property ((strm_state_q == ST_RUN) |-> ({1'b0, strm_prof_q} < 4'(NUM_PROFILES)))
		else $error("streamer runs an absent profile");
	a_strm_err_hold: assert property ((strm_err_q && !strm_go) |=> strm_err_q)
		else $error("error flag lost without a start");
endmodule
`default_nettype wire

// ---- design/reconfig_port_pkg.sv ----
/*
 Package for the transceiver reconfiguration access port: address layout,
 soft register offsets, field positions, reset values and carrier types.
 Assumes a single 100 MHz clock domain and word-addressed offsets.
*/
package reconfig_port_pkg;
	localparam int NUM_CH     = 4;
	localparam int CH_W       = 2;
	localparam int OFF_W      = 19;
	localparam int ADDR_W     = OFF_W + CH_W;
	localparam int DATA_W     = 32;
	localparam int ATTR_AW    = 6;
	localparam int ATTR_WORDS = 64;
	localparam int PROF_MAX   = 8;
	localparam int PROF_PW    = 3;
	localparam int PROF_IW    = 2;
	localparam int PROF_WORDS = 4;
	localparam int CTRL_W     = 8;

	localparam logic [OFF_W-1:0] CAP_NUM_CH_OFF  = 19'h40000;
	localparam logic [OFF_W-1:0] CAP_USER_ID_OFF = 19'h40001;
	localparam logic [OFF_W-1:0] CAP_FEATURE_OFF = 19'h40002;
	localparam logic [OFF_W-1:0] CSR_CTRL_OFF    = 19'h40010;
	localparam logic [OFF_W-1:0] CSR_STATUS_OFF  = 19'h40011;
	localparam logic [OFF_W-1:0] STRM_CTRL_OFF   = 19'h40018;
	localparam logic [OFF_W-1:0] STRM_STATUS_OFF = 19'h40019;
	localparam logic [OFF_W-1:0] PROF_BASE_OFF   = 19'h40100;

	localparam int CTRL_PROF_LSB   = 0;
	localparam int CTRL_CH_LSB     = 4;
	localparam int CTRL_START_BIT  = 8;
	localparam int STATUS_ARB_BIT  = 31;
	localparam int SSTAT_BUSY_BIT  = 4;
	localparam int SSTAT_ERR_BIT   = 5;

	localparam logic [CTRL_W-1:0] PHY_CTRL_RST = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              wr;
		logic              rd;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef enum logic [1:0] {OWN_USER, OWN_DBG, OWN_STRM} owner_t;
	typedef enum logic {ST_IDLE, ST_RUN} strm_state_t;
endpackage

// ---- test/reconfig_master_model.sv ----
/*
 User-side master model for the reconfiguration port: one-cycle strobes.
 Assumes tasks are entered just after a rising edge, from one process.
*/
`timescale 1ns/10ps
`default_nettype none
module reconfig_master_model
	import reconfig_port_pkg::*;
(
	input  wire logic              sys_clk, // System clock
	input  wire logic              waitreq, // Port stall
	input  wire logic [DATA_W-1:0] rdata,   // Read data
	output var  bus_req_t          req      // Request to port
);
	initial req = '0;
	task automatic grant(input logic [OFF_W-1:0] off);
		int n;
		n = 0;
		while (off < 19'h40 && waitreq === 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic wr(input logic [CH_W-1:0] ch, input logic [OFF_W-1:0] off, input logic [DATA_W-1:0] d);
		grant(off);
		req <= '{addr: {ch, off}, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge sys_clk);
		// Released lines never keep the old value
		req <= '{addr: ~{ch, off}, wr: 1'b0, rd: 1'b0, wdata: ~d};
		// Idle edge, so a following call never reassigns req in one step
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [CH_W-1:0] ch, input logic [OFF_W-1:0] off, output logic [DATA_W-1:0] d);
		grant(off);
		req <= '{addr: {ch, off}, wr: 1'b0, rd: 1'b1, wdata: 32'h0};
		@(posedge sys_clk);
		req <= '{addr: ~{ch, off}, wr: 1'b0, rd: 1'b0, wdata: 32'hffffffff};
		@(posedge sys_clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ---- test/transceiver_reconfig_access_port_test.sv ----
/*
 Self-checking bench for the reconfiguration access port.
 Assumes the master model in reconfig_master_model.sv and the port package.
*/
`timescale 1ns/10ps
`default_nettype none
module transceiver_reconfig_access_port_test
	import reconfig_port_pkg::*;
;
	localparam int NPROF = 6;
	logic              sys_clk = 1'b0;
	logic              reset = 1'b1;
	logic              dbg_req = 1'b0;
	logic              reconfig_waitrequest;
	logic              strm_busy;
	bus_req_t          user_req;
	bus_req_t          dbg_bus = '0;
	logic [DATA_W-1:0] user_rdata;
	logic [DATA_W-1:0] dbg_rdata;
	logic [DATA_W-1:0] d;
	logic [CTRL_W-1:0] phy_status = 8'h00;
	logic [CTRL_W-1:0] phy_ctrl;
	int                failures = 0;
	int                n_checks = 0;
	int                seed = 51049;
	int                cycles = 0;
	int                busy_n = 0;
	logic [DATA_W-1:0] mem [int];

	always #5 sys_clk = ~sys_clk;
	// Counts cycles in which the streamer stood busy
	always @(posedge sys_clk) busy_n <= busy_n + int'(strm_busy);

	reconfig_access_port #(.NUM_PROFILES(NPROF)) u_reconfig_access_port (
		.sys_clk(sys_clk), .reset(reset), .user_req(user_req), .user_rdata(user_rdata),
		.reconfig_waitrequest(reconfig_waitrequest), .dbg_req(dbg_req), .dbg_bus(dbg_bus),
		.dbg_rdata(dbg_rdata), .phy_status(phy_status), .phy_ctrl(phy_ctrl), .strm_busy(strm_busy)
	);
	reconfig_master_model u_master (
		.sys_clk(sys_clk), .waitreq(reconfig_waitrequest), .rdata(user_rdata), .req(user_req)
	);

	task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		logic [CH_W-1:0]  ch;
		logic [OFF_W-1:0] off;
		logic [DATA_W-1:0] v;
		int               p;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk("waitrequest", {31'h0, reconfig_waitrequest}, 32'h0);
		chk("phy_ctrl", {24'h0, phy_ctrl}, {24'h0, PHY_CTRL_RST});
		u_master.rd(0, CAP_NUM_CH_OFF, d);
		chk("num channels", d, 32'(NUM_CH));
		u_master.rd(0, CAP_USER_ID_OFF, d);
		chk("user id", d, 32'h0);
		u_master.rd(1, CAP_FEATURE_OFF, d);
		chk("features", d, 32'(NPROF * 256 + 11));
		u_master.rd(0, 19'h7ffff, d);
		chk("unmapped", d, 32'h0);
		// Same offset in every channel, then random spread
		for (int i = 0; i < 28; i++) begin
			ch = (i < 4) ? i[1:0] : CH_W'($random(seed));
			off = (i < 4) ? 19'h3f : OFF_W'($random(seed)) & 19'h3f;
			v = $random(seed);
			u_master.wr(ch, off, v);
			mem[{ch, off}] = v;
			u_master.rd(ch, off, d);
			chk("channel echo", d, v);
		end
		foreach (mem[k]) begin
			u_master.rd(k[20:19], k[18:0], d);
			chk("channel word", d, mem[k]);
		end
		v = $random(seed);
		u_master.wr(0, CSR_CTRL_OFF, v);
		@(posedge sys_clk);
		chk("phy_ctrl", {24'h0, phy_ctrl}, {24'h0, v[7:0]});
		phy_status <= CTRL_W'($random(seed));
		repeat (3) @(posedge sys_clk);
		u_master.rd(0, CSR_STATUS_OFF, d);
		chk("status", d, {24'h0, phy_status});
		dbg_req <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("waitrequest dbg", {31'h0, reconfig_waitrequest}, 32'h1);
		u_master.rd(0, CSR_STATUS_OFF, d);
		chk("arb bit", {31'h0, d[STATUS_ARB_BIT]}, 32'h1);
		v = $random(seed);
		dbg_bus <= '{addr: {2'h2, 19'h11}, wr: 1'b1, rd: 1'b0, wdata: v};
		@(posedge sys_clk);
		dbg_bus <= '{addr: {2'h2, 19'h11}, wr: 1'b0, rd: 1'b1, wdata: ~v};
		@(posedge sys_clk);
		dbg_bus <= '{addr: {2'h0, CAP_NUM_CH_OFF}, wr: 1'b0, rd: 1'b1, wdata: v};
		@(posedge sys_clk);
		chk("dbg read", dbg_rdata, v);
		dbg_bus <= '{addr: ~{2'h2, 19'h11}, wr: 1'b0, rd: 1'b0, wdata: v};
		@(posedge sys_clk);
		chk("dbg capability", dbg_rdata, 32'(NUM_CH));
		dbg_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("waitrequest back", {31'h0, reconfig_waitrequest}, 32'h0);
		u_master.rd(2, 19'h11, d);
		chk("dbg write", d, v);
		// Last valid profile streams into channel 3
		for (int e = 0; e < PROF_WORDS; e++)
			u_master.wr(0, PROF_BASE_OFF + OFF_W'(4 * (NPROF - 1) + e), 32'h5a000000 + e);
		p = busy_n;
		u_master.wr(0, STRM_CTRL_OFF, 32'h130 + NPROF - 1);
		repeat (8) @(posedge sys_clk);
		chk("busy cycles", 32'(busy_n - p), 32'(PROF_WORDS));
		for (int e = 0; e < PROF_WORDS; e++) begin
			u_master.rd(3, OFF_W'(e), d);
			chk("streamed word", d, 32'h5a000000 + e);
		end
		u_master.wr(0, STRM_CTRL_OFF, 32'h100 + NPROF);
		repeat (2) @(posedge sys_clk);
		u_master.rd(0, STRM_STATUS_OFF, d);
		chk("bad profile", {30'h0, d[SSTAT_ERR_BIT], d[SSTAT_BUSY_BIT]}, 32'h2);
		close_out();
	end
endmodule
`default_nettype wire
